// File: dv/tb_skip_compare_port_set_decode.sv
// Self-checking testbench of the indexed port set and compare-immediate skip decoder.
`timescale 1ns/1ns
module tb_skip_compare_port_set_decode;
	logic                   core_clk;
	logic                   nrst;
	scp_pkg::scp_fetch_type fetch;
	logic [3:0]             accVal;
	logic [3:0]             idxVal;
	logic [3:0]             portD;
	logic                   pcStep;
	logic                   skipping;
	logic                   cmpEqual_q;
	logic                   cmpDone_q;
	logic [31:0]            lfsr;
	logic [3:0]             expP;
	logic [3:0]             a;
	logic                   expEq;
	logic                   expDone;
	logic                   mOp;
	logic                   mSkip;
	logic                   mSkip2;
	int                     errors;
	int                     n_tests;

	scp_skip_compare_decode uut (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.fetch      (fetch),
		.accVal     (accVal),
		.idxVal     (idxVal),
		.portD      (portD),
		.pcStep     (pcStep),
		.skipping   (skipping),
		.cmpEqual_q (cmpEqual_q),
		.cmpDone_q  (cmpDone_q)
	);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Expected port D mask of an indexed set; out-of-range indices give none.
	function automatic logic [3:0] set_mask(input logic [3:0] ix);
		return (ix <= scp_pkg::IDX_LIMIT) ? (4'h1 << ix[1:0]) : 4'h0;
	endfunction

	task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check_all;
		chk("portD", portD, expP);
		chk("skipping", {3'h0, skipping}, {3'h0, mSkip | mSkip2});
		chk("cmpEqual", {3'h0, cmpEqual_q}, {3'h0, expEq});
		chk("cmpDone", {3'h0, cmpDone_q}, {3'h0, expDone});
	endtask

	task automatic do_reset(input int n);
		nrst = 1'b0;
		fetch.valid = 1'b0;
		repeat (n) @(negedge core_clk);
		nrst = 1'b1;
		{expP, expEq, expDone, mOp, mSkip, mSkip2} = '0;
		check_all();
	endtask

	// Presents one word at the falling edge and updates the reference model.
	task automatic step(input logic v, input logic [9:0] w, input logic [3:0] ac,
		input logic [3:0] ix);
		fetch.valid = v;
		fetch.word = w;
		accVal = ac;
		idxVal = ix;
		#1;
		chk("pcStep", {3'h0, pcStep}, {3'h0, v});
		@(posedge core_clk);
		expDone = 1'b0;
		if (v) begin
			if (mSkip2) mSkip2 = 1'b0;
			else if (mSkip) begin
				mSkip = 1'b0;
				mSkip2 = (w == scp_pkg::OP_CMP_FIRST);
			end
			else if (mOp) begin
				mOp = 1'b0;
				expDone = 1'b1;
				expEq = (w[3:0] == ac);
				mSkip = expEq;
			end
			else if (w == scp_pkg::OP_CMP_FIRST) mOp = 1'b1;
			else if (w == scp_pkg::OP_SET_PORT) expP = expP | set_mask(ix);
		end
		@(negedge core_clk);
		check_all();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		n_tests = 0;
		lfsr = 32'hf748;
		fetch = '0;
		accVal = 4'h0;
		idxVal = 4'h0;
		do_reset(4);
		for (int i = 7; i >= 0; i--) step(1'b1, scp_pkg::OP_SET_PORT, 4'h0, i[3:0]);
		do_reset(1);
		step(1'b1, scp_pkg::OP_CMP_FIRST, 4'h5, 4'h0);
		step(1'b1, {scp_pkg::OP_CMP_OPND, 4'h5}, 4'h5, 4'h0);
		step(1'b1, scp_pkg::OP_CMP_FIRST, 4'h5, 4'h0);
		step(1'b1, {scp_pkg::OP_CMP_OPND, 4'h5}, 4'h5, 4'h0);
		step(1'b1, scp_pkg::OP_SET_PORT, 4'h0, 4'h2);
		step(1'b1, scp_pkg::OP_CMP_FIRST, 4'h3, 4'h0);
		step(1'b0, 10'h3ff, 4'h3, 4'h0);
		step(1'b1, {scp_pkg::OP_CMP_OPND, 4'h9}, 4'h3, 4'h0);
		step(1'b1, scp_pkg::OP_SET_PORT, 4'h0, 4'h1);
		step(1'b1, scp_pkg::OP_CMP_FIRST, 4'hf, 4'h0);
		step(1'b1, {scp_pkg::OP_CMP_OPND, 4'hf}, 4'hf, 4'h0);
		step(1'b1, scp_pkg::OP_SET_PORT, 4'h0, 4'h3);
		repeat (3000) begin
			lfsr = lfsr_next(lfsr);
			a = lfsr[19:16];
			if (lfsr[31:26] == 6'h00) do_reset(1);
			case (lfsr[11:9])
				3'h0, 3'h1: step(1'b1, scp_pkg::OP_SET_PORT, a, lfsr[23:20]);
				3'h2, 3'h3: step(1'b1, scp_pkg::OP_CMP_FIRST, a, lfsr[23:20]);
				3'h4, 3'h5: step(1'b1, {scp_pkg::OP_CMP_OPND, lfsr[12] ? a : lfsr[15:12]}, a,
					lfsr[23:20]);
				3'h6: step(1'b1, lfsr[29:20], a, lfsr[23:20]);
				default: step(1'b0, lfsr[29:20], a, lfsr[23:20]);
			endcase
		end
		stop_test();
	end
endmodule // tb_skip_compare_port_set_decode

// File: hw/scp_port_d_reg.sv
// Port D output register with single-bit set by index.
`timescale 1ns/1ns
module scp_port_d_reg (
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	input  wire scp_pkg::scp_port_set_type  setReq,
	output logic [scp_pkg::PORT_W-1:0]      portD
);

	logic [scp_pkg::PORT_W-1:0] portD_q;
	logic [scp_pkg::PORT_W-1:0] portD_d;
	logic [scp_pkg::PORT_W-1:0] bitMask;

	assign bitMask = scp_pkg::PORT_W'(1) << setReq.bitSel;
	assign portD_d = setReq.setEn ? (portD_q | bitMask) : portD_q;
	assign portD   = portD_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			portD_q <= scp_pkg::PORT_RESET;
		end else begin
			portD_q <= portD_d;
		end
	end

endmodule // scp_port_d_reg

// File: hw/scp_skip_compare_decode.sv
// Decoder and executor for indexed port set and compare-immediate skip.
// Overview of operation
// - Indexed set drives one chosen port D bit.
// - Index above three makes instruction a no-op.
// - Compare is fixed first word plus operand.
// - Compare consumes two words before completing.
// - Equal values skip the following instruction.
// - Unequal continues normally; only cmpEqual_q and cmpDone_q change.
`timescale 1ns/1ns
module scp_skip_compare_decode (
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire scp_pkg::scp_fetch_type   fetch,
	input  wire logic [3:0]               accVal,
	input  wire logic [3:0]               idxVal,
	output logic [scp_pkg::PORT_W-1:0]    portD,
	output logic                          pcStep,
	output logic                          skipping,
	output logic                          cmpEqual_q,
	output logic                          cmpDone_q
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding.

	scp_pkg::scp_state_type state_q;
	scp_pkg::scp_state_type state_d;
	scp_pkg::scp_port_set_type setReq;

	logic       cmpEqual_d;
	logic       cmpDone_d;
	logic       inExec;
	logic       isSetPort;
	logic       idxInRange;
	logic       isCmpFirst;
	logic       operandTake;
	logic       immEqual;
	logic [3:0] immVal;

	// Matches the fixed first word of the compare instruction.
	function automatic logic cmpFirstMatch(input logic [9:0] w);
		cmpFirstMatch = (w == scp_pkg::OP_CMP_FIRST);
	endfunction

	// Reports whether an index selects one of the port bits.
	function automatic logic indexValid(input logic [3:0] idx);
		indexValid = (idx <= scp_pkg::IDX_LIMIT);
	endfunction

	assign inExec      = fetch.valid && (state_q == scp_pkg::ST_EXEC);
	assign isSetPort   = inExec && (fetch.word == scp_pkg::OP_SET_PORT);
	assign idxInRange  = indexValid(idxVal);
	assign isCmpFirst  = inExec && cmpFirstMatch(fetch.word);
	assign operandTake = fetch.valid && (state_q == scp_pkg::ST_OPERAND);
	assign immVal      = fetch.word[scp_pkg::IMM_LSB +: scp_pkg::NIB_W];
	assign immEqual    = (accVal == immVal);

	////////////////////////////////////////////////////////////////////////////
	// Port D execution.

	assign setReq.setEn  = isSetPort && idxInRange;
	assign setReq.bitSel = idxVal[scp_pkg::IDX_W-1:0];

	scp_port_d_reg uPortD (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setReq   (setReq),
		.portD    (portD)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencing.

	assign pcStep   = fetch.valid;
	assign skipping = (state_q == scp_pkg::ST_SKIP) || (state_q == scp_pkg::ST_SKIP_OPERAND);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			scp_pkg::ST_EXEC: begin
				if (isCmpFirst) begin
					state_d = scp_pkg::ST_OPERAND;
				end
			end
			scp_pkg::ST_OPERAND: begin
				if (fetch.valid) begin
					state_d = immEqual ? scp_pkg::ST_SKIP : scp_pkg::ST_EXEC;
				end
			end
			scp_pkg::ST_SKIP: begin
				if (fetch.valid) begin
					state_d = cmpFirstMatch(fetch.word) ? scp_pkg::ST_SKIP_OPERAND
						: scp_pkg::ST_EXEC;
				end
			end
			scp_pkg::ST_SKIP_OPERAND: begin
				if (fetch.valid) begin
					state_d = scp_pkg::ST_EXEC;
				end
			end
		endcase
	end

	assign cmpDone_d  = operandTake;
	assign cmpEqual_d = operandTake ? immEqual : cmpEqual_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q    <= scp_pkg::ST_EXEC;
			cmpEqual_q <= 1'b0;
			cmpDone_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			cmpEqual_q <= cmpEqual_d;
			cmpDone_q  <= cmpDone_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	setBit_a: assert property (
		isSetPort && idxInRange |=> portD[$past(idxVal[1:0])] == 1'b1
	) else $error("Indexed set did not raise the chosen port bit.");

	setOther_a: assert property (
		isSetPort && idxInRange |=> ($past(portD) & ~portD) == 4'h0
	) else $error("Indexed set cleared another port bit.");

	noopIndex_a: assert property (
		isSetPort && !idxInRange |=> $stable(portD) && state_q == scp_pkg::ST_EXEC
	) else $error("Out-of-range index changed the port or state.");

	cmpDecode_a: assert property (
		isCmpFirst |=> state_q == scp_pkg::ST_OPERAND && $stable(portD)
	) else $error("Compare first word not decoded.");

	operandWait_a: assert property (
		state_q == scp_pkg::ST_OPERAND && !fetch.valid |=> state_q == scp_pkg::ST_OPERAND
	) else $error("Compare completed without its second word.");

	skipEqual_a: assert property (
		operandTake && immEqual |=> skipping && cmpDone_q && cmpEqual_q
	) else $error("Equal compare did not start a skip.");

	noSkip_a: assert property (
		operandTake && !immEqual |=> state_q == scp_pkg::ST_EXEC && !cmpEqual_q
	) else $error("Unequal compare did not resume execution.");

	skipQuiet_a: assert property (
		skipping && fetch.valid |=> $stable(portD)
	) else $error("Skipped instruction changed port D.");

	skipEnd_a: assert property (
		state_q == scp_pkg::ST_SKIP && fetch.valid && !cmpFirstMatch(fetch.word)
			|=> state_q == scp_pkg::ST_EXEC
	) else $error("Skip did not end after one instruction.");

	////////////////////////////////////////////////////////////////////////////
	// Checks on flags, operand words, idle cycles and skipped words.

	skipOperand_a: assert property (
		state_q == scp_pkg::ST_SKIP_OPERAND && fetch.valid
			|=> state_q == scp_pkg::ST_EXEC && $stable(portD)
	) else $error("Skipped operand word was not discarded.");

	skipTwoWords_a: assert property (
		state_q == scp_pkg::ST_SKIP && fetch.valid && cmpFirstMatch(fetch.word)
			|=> state_q == scp_pkg::ST_SKIP_OPERAND && skipping
	) else $error("Skipped compare did not discard its second word.");

	skipWait_a: assert property (
		skipping && !fetch.valid |=> skipping && $stable(state_q)
	) else $error("Skip ended without a fetched word.");

	skipFlags_a: assert property (
		skipping |=> !cmpDone_q && $stable(cmpEqual_q)
	) else $error("Skipped instruction changed a compare flag.");

	doneOnce_a: assert property (
		cmpDone_q |=> !cmpDone_q
	) else $error("Compare completion lasted more than one cycle.");

	doneSkip_a: assert property (
		cmpDone_q |-> skipping == cmpEqual_q
	) else $error("Skip state disagrees with the compare result.");

	cmpHold_a: assert property (
		!operandTake |=> $stable(cmpEqual_q)
	) else $error("Compare result changed without a compare.");

	operandPort_a: assert property (
		state_q == scp_pkg::ST_OPERAND |=> $stable(portD)
	) else $error("Compare operand word changed port D.");

	idleHold_a: assert property (
		!fetch.valid |=> $stable(state_q) && $stable(portD)
	) else $error("State or port moved without a fetched word.");

	setFlags_a: assert property (
		isSetPort |=> !skipping && !cmpDone_q && $stable(cmpEqual_q)
	) else $error("Indexed set changed a compare flag or the state.");

	firstQuiet_a: assert property (
		isCmpFirst |=> !cmpDone_q && $stable(cmpEqual_q) && !skipping
	) else $error("Compare first word completed the compare early.");

	setSeen_c: cover property (setReq.setEn);
	cmpSkip_c: cover property (isCmpFirst ##[1:4] (operandTake && immEqual) ##[1:4] fetch.valid);
	cmpNoSkip_c: cover property (isCmpFirst ##[1:4] (operandTake && !immEqual));
	skipTwo_c: cover property (state_q == scp_pkg::ST_SKIP_OPERAND);
	noopSeen_c: cover property (isSetPort && !idxInRange);

endmodule // scp_skip_compare_decode

// File: inc/scp_pkg.sv
// Package with opcodes, field layouts, states and carriers of the decode block.
package scp_pkg;

	localparam int          WORD_W       = 10;
	localparam int          NIB_W        = 4;
	localparam int          PORT_W       = 4;
	localparam int          IDX_W        = 2;
	localparam int          IMM_LSB      = 0;
	localparam int          OPERAND_LSB  = 4;
	localparam int          OPERAND_MSB  = 9;
	localparam logic [9:0]  OP_SET_PORT  = 10'h015;
	localparam logic [9:0]  OP_CMP_FIRST = 10'h025;
	localparam logic [5:0]  OP_CMP_OPND  = 6'h07;
	localparam logic [3:0]  IDX_LIMIT    = 4'h3;
	localparam logic [3:0]  PORT_RESET   = 4'h0;
	localparam int          CMP_WORDS    = 2;

	typedef enum logic [1:0] {
		ST_EXEC         = 2'b00,
		ST_OPERAND      = 2'b01,
		ST_SKIP         = 2'b10,
		ST_SKIP_OPERAND = 2'b11
	} scp_state_type;

	typedef struct packed {
		logic        valid;
		logic [9:0]  word;
	} scp_fetch_type;

	typedef struct packed {
		logic        setEn;
		logic [1:0]  bitSel;
	} scp_port_set_type;

endpackage
